// ==== rtl/dawp_top.sv ====
// Function
// - wrap clear: memory wraps at 64K maps, char counter limited to 16 bits
// - wrap set: memory wraps at installed size, char counter 17 bits
// - wrap and chain-4: dram a0/a1 from cpu address bits 16/17, not 14/15
// - extended cpu address 18:12 = cpu bank bits 16:12 plus chosen offset
// - wrap and double-word: dram a0/a1 from counter bits 14/15, not 12/13
// - double-word remap gives four displayable pages in 320-wide 256-color mode
// - wrap and four drams installed: counter bit 16 joins display address, 128k page
// - extended control bit 0 is display start address bit 16
// - class 00 mono panels; format bit 0 dual scan, 1 single scan
// - class 01 one unshaded 4-bit pixel on lower nibble
// - class 10 color stn; stn bit 0 single, 1 dual scan
// - class 11 color tft; width field picks 9, 12 or 18 bits
// - panel register reached at 3b5 mono or 3d5 color via index
// - vertical blanking bit 0 keeps display enable unblanked vertically
`timescale 1ns/1ps
`include "dawp_map.svh"
module dawp_top
   import dawp_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // indexed io port
   input wire logic i_color_mode,
   input wire logic [15:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_wdata,
   output logic [7:0] o_io_rdata,
   // memory address inputs
   input wire logic i_chain_four_select,
   input wire logic i_double_word_select,
   input wire logic i_four_drams,
   input wire logic i_bank_sel,
   input wire logic [6:0] i_bank_offset0,
   input wire logic [6:0] i_bank_offset1,
   input wire logic [16:0] i_cpu_bank_addr,
   input wire logic [16:0] i_char_counter_addr,
   input wire logic [15:0] i_disp_start_low,
   // memory address outputs
   output logic [18:0] o_extended_cpu_mem_addr,
   output logic [18:0] o_cpu_dram_addr,
   output logic [18:0] o_disp_dram_addr,
   output logic [16:0] o_disp_start_addr,
   output logic o_char_counter_17,
   // panel inputs
   input wire logic i_mono_scan_select,
   input wire logic i_stn_dual_scan_select,
   input wire logic [1:0] i_tft_width_select,
   input wire logic i_de_raw,
   input wire logic i_vblank,
   // panel outputs
   output dawp_class_type o_panel_class,
   output logic o_dual_scan,
   output logic [1:0] o_tft_width,
   output logic o_nibble_upper_en,
   output logic o_panel_de
);
   dawp_state_type st_r, st_nxt;
   logic idx_hit;
   logic data_hit;
   logic ext_sel;
   logic pif_sel;
   logic wrap;
   logic four_bank;
   logic vblank_en;
   logic [6:0] ofs;
   logic [6:0] bank_sum;
   logic [18:0] extended_cpu_mem_addr;
   logic [18:0] xma_lim;
   logic [18:0] ca;
   dawp_class_type cls;

   // index or data port address for the current colour mode
   function automatic logic [15:0] port_addr(input logic color, input logic data);
      logic [15:0] p;
      if (color) begin
         p = data ? `DAWP_PORT_COLOR : `DAWP_PORT_IDX_COLOR;
      end else begin
         p = data ? `DAWP_PORT_MONO : `DAWP_PORT_IDX_MONO;
      end
      return p;
   endfunction

   // keeps only the implemented bits of a register write
   function automatic logic [7:0] keep_bits(input logic [7:0] v, input logic [7:0] mask);
      return v & mask;
   endfunction

   // swaps address bits 1:0 with the pair that starts at lo
   function automatic logic [18:0] swap_a01(input logic [18:0] a, input int lo);
      logic [18:0] r;
      r = a;
      r[lo] = a[0];
      r[lo+1] = a[1];
      r[0] = a[lo];
      r[1] = a[lo+1];
      return r;
   endfunction

   // port and index decode
   always_comb begin
      idx_hit = i_io_addr == port_addr(i_color_mode, 1'b0);
      data_hit = i_io_addr == port_addr(i_color_mode, 1'b1);
      ext_sel = st_r.idx == `DAWP_IDX_EXT_DISP;
      pif_sel = st_r.idx == `DAWP_IDX_PANEL_IF;
   end

   // register state: index, two registers, read data
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 8'h00;
      if (i_io_wr && idx_hit) begin
         st_nxt.idx = i_io_wdata;
      end
      if (i_io_wr && data_hit && ext_sel) begin
         st_nxt.ext_disp = keep_bits(i_io_wdata, `DAWP_EXT_MASK);
      end
      if (i_io_wr && data_hit && pif_sel) begin
         st_nxt.panel_if = keep_bits(i_io_wdata, `DAWP_PIF_MASK);
      end
      if (i_io_rd && idx_hit) begin
         st_nxt.rdata = st_r.idx;
      end else if (i_io_rd && data_hit && ext_sel) begin
         st_nxt.rdata = st_r.ext_disp;
      end else if (i_io_rd && data_hit && pif_sel) begin
         st_nxt.rdata = st_r.panel_if;
      end
      if (!i_rst_n) begin
         st_nxt.idx = 8'h00;
         st_nxt.ext_disp = `DAWP_EXT_RST;
         st_nxt.panel_if = `DAWP_PIF_RST;
         st_nxt.rdata = 8'h00;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      st_r <= st_nxt;
   end

   // cpu side: bank offset add and wrap limit
   always_comb begin
      wrap = st_r.ext_disp[`DAWP_BIT_WRAP];
      ofs = i_bank_sel ? i_bank_offset1 : i_bank_offset0;
      bank_sum = 7'(ofs + {2'b00, i_cpu_bank_addr[16:12]});
      extended_cpu_mem_addr = {bank_sum, i_cpu_bank_addr[11:0]};
      xma_lim = extended_cpu_mem_addr;
      if (!wrap) begin
         xma_lim[18:16] = 3'b000;
      end
   end

   // cpu side: chain-4 remap of dram bits 1:0
   always_comb begin
      o_extended_cpu_mem_addr = extended_cpu_mem_addr;
      if (i_chain_four_select && wrap) begin
         o_cpu_dram_addr = swap_a01(xma_lim, 16);
      end else if (i_chain_four_select) begin
         o_cpu_dram_addr = swap_a01(xma_lim, 14);
      end else begin
         o_cpu_dram_addr = xma_lim;
      end
   end

   // display side: counter width and double-word remap
   always_comb begin
      four_bank = wrap && i_four_drams;
      ca = {2'b00, i_char_counter_addr};
      if (!four_bank) begin
         ca[16] = 1'b0;
      end
      if (i_double_word_select && wrap) begin
         o_disp_dram_addr = swap_a01(ca, 14);
      end else if (i_double_word_select) begin
         o_disp_dram_addr = swap_a01(ca, 12);
      end else begin
         o_disp_dram_addr = ca;
      end
      o_char_counter_17 = wrap;
      o_disp_start_addr = {st_r.ext_disp[`DAWP_BIT_START16], i_disp_start_low};
   end

   // panel class decode
   always_comb begin
      cls = dawp_class_type'(st_r.panel_if[`DAWP_BIT_CLASS_HI:`DAWP_BIT_CLASS_LO]);
      o_panel_class = cls;
      o_dual_scan = 1'b0;
      o_tft_width = 2'b00;
      o_nibble_upper_en = 1'b0;
      unique case (cls)
         DAWP_MONO: begin
            o_dual_scan = !i_mono_scan_select;
            o_nibble_upper_en = 1'b1;
         end
         DAWP_MONO_4BIT: begin
            o_nibble_upper_en = 1'b0;
         end
         DAWP_COLOR_STN: begin
            o_dual_scan = i_stn_dual_scan_select;
         end
         DAWP_COLOR_TFT: begin
            o_tft_width = i_tft_width_select;
         end
      endcase
   end

   // display enable: vertical blanking only when software asks for it
   always_comb begin
      vblank_en = st_r.ext_disp[`DAWP_BIT_VBLANK];
      if (vblank_en) begin
         o_panel_de = i_de_raw && !i_vblank;
      end else begin
         o_panel_de = i_de_raw;
      end
   end

   // read data leaves the register directly
   assign o_io_rdata = st_r.rdata;
endmodule

// ==== pkg/dawp_map.svh ====
`ifndef DAWP_MAP_SVH
`define DAWP_MAP_SVH
`define DAWP_IDX_EXT_DISP 8'h1B
`define DAWP_IDX_PANEL_IF 8'h1C
`define DAWP_PORT_MONO 16'h03B5
`define DAWP_PORT_COLOR 16'h03D5
`define DAWP_PORT_IDX_MONO 16'h03B4
`define DAWP_PORT_IDX_COLOR 16'h03D4
`define DAWP_EXT_MASK 8'hE7
`define DAWP_PIF_MASK 8'hCF
`define DAWP_EXT_RST 8'h00
`define DAWP_PIF_RST 8'h00
`define DAWP_BIT_START16 0
`define DAWP_BIT_WRAP 1
`define DAWP_BIT_VBLANK 2
`define DAWP_BIT_CLASS_LO 6
`define DAWP_BIT_CLASS_HI 7
`endif

// ==== pkg/dawp_pkg.sv ====
package dawp_pkg;
   typedef enum logic [1:0] {
      DAWP_MONO,
      DAWP_MONO_4BIT,
      DAWP_COLOR_STN,
      DAWP_COLOR_TFT
   } dawp_class_type;
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] ext_disp;
      logic [7:0] panel_if;
      logic [7:0] rdata;
   } dawp_state_type;
endpackage

// ==== verification/dawp_panel.sv ====
`timescale 1ns/1ps
module dawp_panel (
   // panel timing toward the block
   input logic i_sys_clk,
   output logic o_de_raw,
   output logic o_vblank
);
   logic [3:0] cnt_r = 4'h0;
   always_ff @(posedge i_sys_clk) cnt_r <= cnt_r + 4'h1;
   assign o_de_raw = cnt_r[0];
   assign o_vblank = cnt_r[3];
endmodule

// ==== verification/dawp_top_asserts.sv ====
`timescale 1ns/1ps
module dawp_chk (
   // watched ports
   input logic i_sys_clk, i_rst_n, i_io_rd, i_de_raw, i_vblank, o_panel_de,
   input logic o_char_counter_17, i_chain_four_select, i_double_word_select, i_four_drams,
   input logic [7:0] o_io_rdata,
   input logic [16:0] i_char_counter_addr,
   input logic [18:0] o_cpu_dram_addr, o_disp_dram_addr, o_extended_cpu_mem_addr
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   wrap_clear_a: assert property (!o_char_counter_17 |->
      o_cpu_dram_addr[18:16] == 3'h0) else $error("wrap");
   page_off_a: assert property (!o_char_counter_17 |-> !o_disp_dram_addr[16])
      else $error("page");
   chain_swap_a: assert property (o_char_counter_17 && i_chain_four_select |->
      o_cpu_dram_addr[1:0] == o_extended_cpu_mem_addr[17:16]) else $error("chain");
   dword_swap_a: assert property (o_char_counter_17 && i_double_word_select |->
      o_disp_dram_addr[1:0] == i_char_counter_addr[15:14]) else $error("dword");
   page_bit_a: assert property (o_char_counter_17 && i_four_drams |->
      o_disp_dram_addr[16] == i_char_counter_addr[16]) else $error("bit16");
   de_pass_a: assert property (!i_vblank |-> o_panel_de == i_de_raw)
      else $error("de");
   de_low_a: assert property (!i_de_raw |-> !o_panel_de)
      else $error("blank");
   rdata_idle_a: assert property (!$past(i_io_rd) |-> o_io_rdata == 8'h00)
      else $error("rdata");
   chain_c: cover property (o_char_counter_17 && i_chain_four_select);
   dword_c: cover property (o_char_counter_17 && i_double_word_select);
   blank_c: cover property (i_vblank && i_de_raw && !o_panel_de);
endmodule
bind dawp_top dawp_chk u_chk (.*);

// ==== verification/tb_display_addr_wrap_panel_class.sv ====
`timescale 1ns/1ps
`include "dawp_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
$display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_display_addr_wrap_panel_class import dawp_pkg::*;;
   logic i_sys_clk = 0, i_rst_n = 0, i_io_wr = 0, i_io_rd = 0, i_de_raw, i_vblank;
   logic i_color_mode, i_chain_four_select, i_double_word_select, i_four_drams, i_bank_sel;
   logic i_mono_scan_select, i_stn_dual_scan_select, o_char_counter_17, o_dual_scan;
   logic o_nibble_upper_en, o_panel_de;
   logic [15:0] i_io_addr = 0, i_disp_start_low, pi;
   logic [7:0] i_io_wdata = 0, o_io_rdata, ext = 0, pif = 0, d;
   logic [6:0] i_bank_offset0, i_bank_offset1, xs;
   logic [16:0] i_cpu_bank_addr, i_char_counter_addr, o_disp_start_addr;
   logic [18:0] o_extended_cpu_mem_addr, o_cpu_dram_addr, o_disp_dram_addr, xe;
   logic dx;
   logic [1:0] i_tft_width_select, o_tft_width;
   logic [31:0] lfsr = 32'hea7a_953b;
   dawp_class_type o_panel_class;
   int n_mismatch = 0, num_checks = 0;
   dawp_top DUT (.*);
   dawp_panel u_panel (.i_sys_clk, .o_de_raw(i_de_raw), .o_vblank(i_vblank));
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [18:0] sw(input logic [18:0] a, input int lo);
      logic [18:0] r;
      r = a;
      {r[lo+1], r[lo], r[1], r[0]} = {a[1], a[0], a[lo+1], a[lo]};
      return r;
   endfunction
   task automatic rnd;
      lfsr = step(lfsr);
      {i_color_mode, i_chain_four_select, i_double_word_select, i_four_drams, i_bank_sel,
         i_mono_scan_select, i_stn_dual_scan_select, i_tft_width_select, i_bank_offset0,
         i_bank_offset1} = lfsr[22:0];
      {i_cpu_bank_addr, i_disp_start_low, i_char_counter_addr} = {lfsr, lfsr[17:0]};
   endtask
   task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] v);
      @(negedge i_sys_clk);
      {i_io_addr, i_io_wr, i_io_rd, i_io_wdata} = {a, w, !w, v};
      @(negedge i_sys_clk);
      {i_io_wr, i_io_rd} = 2'h0;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial forever #12.5 i_sys_clk = ~i_sys_clk;
   initial begin
      #20000;
      n_mismatch++;
      final_report;
   end
   initial begin
      rnd;
      repeat (6) @(negedge i_sys_clk);
      i_rst_n = 1;
      for (int i = 0; i < 49; i++) begin
         rnd;
         pi = i_color_mode ? `DAWP_PORT_IDX_COLOR : `DAWP_PORT_IDX_MONO;
         d = lfsr[31:24] | {5'h00, pif[7:6] == 2'h3, 2'h0};
         acc(pi, 1, i == 48 ? 8'h1D : 8'h1B + !i[0]);
         acc(pi + 16'h0001, 1, d);
         acc(pi ^ 16'h0061, 1, ~d);
         if (i[0]) ext = d & `DAWP_EXT_MASK;
         else if (i < 48) pif = d & `DAWP_PIF_MASK;
         acc(pi + 16'h0001, 0, 8'h00);
         `CHK(o_io_rdata, i == 48 ? 8'h00 : i[0] ? ext : pif)
         xs = (i_bank_sel ? i_bank_offset1 : i_bank_offset0) + i_cpu_bank_addr[16:12];
         `CHK(o_extended_cpu_mem_addr[18:12], xs)
         `CHK(o_char_counter_17, ext[1])
         `CHK(o_disp_start_addr, {ext[0], i_disp_start_low})
         `CHK(o_panel_class, pif[7:6])
         `CHK(o_panel_de, ext[2] ? i_de_raw & !i_vblank : i_de_raw)
         xe = {xs, i_cpu_bank_addr[11:0]};
         if (!ext[1]) xe[18:16] = 3'h0;
         if (i_chain_four_select) xe = sw(xe, ext[1] ? 16 : 14);
         `CHK(o_cpu_dram_addr, xe)
         xe = {2'h0, i_char_counter_addr};
         if (!(ext[1] && i_four_drams)) xe[16] = 1'b0;
         if (i_double_word_select) xe = sw(xe, ext[1] ? 14 : 12);
         `CHK(o_disp_dram_addr, xe)
         `CHK(o_nibble_upper_en, pif[7:6] == 2'h0)
         dx = pif[7:6] == 2'h0 ? !i_mono_scan_select : pif[7:6] == 2'h2 && i_stn_dual_scan_select;
         `CHK(o_dual_scan, dx)
         `CHK(o_tft_width, pif[7:6] == 2'h3 ? i_tft_width_select : 2'h0)
      end
      @(negedge i_sys_clk);
      i_rst_n = 0;
      repeat (2) @(negedge i_sys_clk);
      i_rst_n = 1;
      acc(pi, 1, 8'h1B);
      acc(pi + 16'h0001, 0, 8'h00);
      `CHK(o_io_rdata, `DAWP_EXT_RST)
      `CHK(o_char_counter_17, 1'b0)
      final_report;
   end
endmodule
